// ==== include/tsos_pkg.sv ====
// Purpose: constants and types of the start/stop/one-shot timer block
// Assumes: 32-bit AXI4-Lite register bus, one clock
// Notes: all timer registers sit in the low byte lane; PRE, SEC, PRI and DIV are 8 bits wide, MODE 2 bits
package tsos_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OSHOT = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_PRE = 8'h0C;
  localparam logic [7:0] OFS_SEC = 8'h10;
  localparam logic [7:0] OFS_PRI = 8'h14;
  localparam logic [7:0] OFS_DIV = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RUN_BIT = 0;
  localparam int ACT_BIT = 1;
  localparam int HALT_BIT = 2;
  localparam int GO_BIT = 0;
  localparam int OSHALT_BIT = 1;
  localparam int OSACT_BIT = 2;

  // ****************************************
  // reset values and answers
  // ****************************************
  localparam logic [7:0] PRE_RST = 8'hFF;
  localparam logic [7:0] CNT_RST = 8'hFF;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_WAVE = 2'b01,
    MODE_ONESHOT = 2'b10,
    MODE_WAITSHOT = 2'b11
  } tsos_mode_e;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic tick;
    logic [7:0] div;
    logic [7:0] div_rl;
    logic run;
    logic run_s1;
    logic act;
    logic go_p;
    logic go_s;
    logic osh_p;
    logic osh_s;
    logic osa;
    logic phase;
    logic tout;
    tsos_mode_e mode;
    logic [7:0] pre_rl;
    logic [7:0] pre_c;
    logic [7:0] sec_rl;
    logic [7:0] pri_rl;
    logic [7:0] cnt;
  } tsos_st_s;

endpackage

// ==== hdl/tsos_top.sv ====
// Purpose: 8-bit prescaler plus 8-bit counter timer, AXI4-Lite slave
// Assumes: count source is an enable pulse from a divider on aclk
// Notes: run bit changes cross to the count source over two ticks; the halt bit acts at once
`timescale 1ns/1ps
module tsos_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic timer_out
);

  tsos_pkg::tsos_st_s st_r;
  tsos_pkg::tsos_st_s st_nxt;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic counting;
    logic [7:0] d;
    logic oshot;
    counting = 1'b0;
    d = 8'h00;
    st_nxt = st_r;
    oshot = st_r.mode[1];
    // count source divider
    st_nxt.tick = 1'b0;
    if (st_r.div == 8'h00) begin
      st_nxt.div = st_r.div_rl;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.div = st_r.div - 8'h01;
    end
    // count source domain, advanced on each tick
    if (st_r.tick) begin
      st_nxt.run_s1 = st_r.run;
      st_nxt.act = st_r.run_s1;
      if (st_r.act && !st_r.run_s1 && oshot) begin
        st_nxt.pre_c = st_r.pre_rl;
        st_nxt.cnt = st_r.pri_rl;
        st_nxt.osa = 1'b0;
        st_nxt.phase = 1'b0;
        st_nxt.tout = 1'b0;
      end
      st_nxt.go_s = st_r.go_p;
      st_nxt.osh_s = st_r.osh_p;
      if (st_r.go_s) begin
        st_nxt.go_p = 1'b0;
        st_nxt.go_s = 1'b0;
        if (st_r.act && !st_r.osa) begin
          st_nxt.osa = 1'b1;
          st_nxt.tout = (st_r.mode == tsos_pkg::MODE_ONESHOT);
        end
      end
      if (st_r.osh_s) begin
        // a racing go may still win a tick later
        st_nxt.osh_p = 1'b0;
        st_nxt.osh_s = 1'b0;
        st_nxt.osa = 1'b0;
        st_nxt.pre_c = st_r.pre_rl;
        st_nxt.cnt = st_r.pri_rl;
        st_nxt.phase = 1'b0;
        st_nxt.tout = 1'b0;
      end
      counting = st_r.act && (!oshot || st_r.osa);
      if (counting && st_r.run_s1 && !st_r.osh_s) begin
        if (st_r.pre_c != 8'h00) begin
          st_nxt.pre_c = st_r.pre_c - 8'h01;
        end else begin
          st_nxt.pre_c = st_r.pre_rl;
          if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
          end else begin
            case (st_r.mode)
              tsos_pkg::MODE_TIMER: begin
                st_nxt.cnt = st_r.pri_rl;
                st_nxt.tout = !st_r.tout;
              end
              tsos_pkg::MODE_WAVE: begin
                st_nxt.cnt = st_r.phase ? st_r.pri_rl : st_r.sec_rl;
                st_nxt.phase = !st_r.phase;
                st_nxt.tout = !st_r.phase;
              end
              tsos_pkg::MODE_ONESHOT: begin
                st_nxt.cnt = st_r.pri_rl;
                st_nxt.osa = 1'b0;
                st_nxt.tout = 1'b0;
              end
              default: begin
                st_nxt.cnt = st_r.phase ? st_r.pri_rl : st_r.sec_rl;
                st_nxt.phase = !st_r.phase;
                st_nxt.tout = !st_r.phase;
                st_nxt.osa = !st_r.phase;
              end
            endcase
          end
        end
      end
    end
    // ****************************************
    // bus side
    // ****************************************
    if (bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (awvalid && st_r.awready) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_a = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_d = wdata;
      st_nxt.w_s = wstrb[0];
    end
    if (st_r.aw_v && st_r.w_v && !st_r.bvalid) begin
      d = st_r.w_d[7:0];
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = tsos_pkg::RESP_OKAY;
      if (!st_r.w_s) begin
        st_nxt.bresp = tsos_pkg::RESP_OKAY;
      end else if (st_r.aw_a == tsos_pkg::OFS_CTRL) begin
        st_nxt.run = d[tsos_pkg::RUN_BIT];
        if (d[tsos_pkg::HALT_BIT]) begin
          // bypasses the sync chain on purpose
          st_nxt.run = 1'b0;
          st_nxt.run_s1 = 1'b0;
          st_nxt.act = 1'b0;
          st_nxt.osa = 1'b0;
          st_nxt.go_p = 1'b0;
          st_nxt.go_s = 1'b0;
          st_nxt.tout = 1'b0;
        end
      end else if (st_r.aw_a == tsos_pkg::OFS_OSHOT) begin
        if (d[tsos_pkg::GO_BIT] && oshot && !st_r.osa) begin
          st_nxt.go_p = 1'b1;
        end
        if (d[tsos_pkg::OSHALT_BIT] && oshot) begin
          st_nxt.osh_p = 1'b1;
        end
      end else if (st_r.aw_a == tsos_pkg::OFS_MODE) begin
        st_nxt.mode = tsos_pkg::tsos_mode_e'(d[1:0]);
      end else if (st_r.aw_a == tsos_pkg::OFS_PRE) begin
        st_nxt.pre_rl = d;
        if (!st_r.act) begin
          st_nxt.pre_c = d;
        end
      end else if (st_r.aw_a == tsos_pkg::OFS_SEC) begin
        st_nxt.sec_rl = d;
      end else if (st_r.aw_a == tsos_pkg::OFS_PRI) begin
        st_nxt.pri_rl = d;
        if (!st_r.act) begin
          st_nxt.cnt = d;
        end
      end else if (st_r.aw_a == tsos_pkg::OFS_DIV) begin
        st_nxt.div_rl = d;
      end else begin
        st_nxt.bresp = tsos_pkg::RESP_SLVERR;
      end
    end
    if (arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = tsos_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (araddr == tsos_pkg::OFS_CTRL) begin
        st_nxt.rdata[tsos_pkg::RUN_BIT] = st_r.run;
        st_nxt.rdata[tsos_pkg::ACT_BIT] = st_r.act;
      end else if (araddr == tsos_pkg::OFS_OSHOT) begin
        st_nxt.rdata[tsos_pkg::OSACT_BIT] = st_r.osa;
      end else if (araddr == tsos_pkg::OFS_MODE) begin
        st_nxt.rdata[1:0] = st_r.mode;
      end else if (araddr == tsos_pkg::OFS_PRE) begin
        // live count, not latched with the primary byte
        st_nxt.rdata[7:0] = st_r.pre_c;
      end else if (araddr == tsos_pkg::OFS_SEC) begin
        st_nxt.rdata[7:0] = st_r.sec_rl;
      end else if (araddr == tsos_pkg::OFS_PRI) begin
        st_nxt.rdata[7:0] = st_r.cnt;
      end else if (araddr == tsos_pkg::OFS_DIV) begin
        st_nxt.rdata[7:0] = st_r.div_rl;
      end else begin
        st_nxt.rresp = tsos_pkg::RESP_SLVERR;
      end
    end
    st_nxt.awready = !st_nxt.aw_v;
    st_nxt.wready = !st_nxt.w_v;
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.pre_rl <= tsos_pkg::PRE_RST;
      st_r.pre_c <= tsos_pkg::PRE_RST;
      st_r.pri_rl <= tsos_pkg::CNT_RST;
      st_r.cnt <= tsos_pkg::CNT_RST;
      st_r.sec_rl <= tsos_pkg::CNT_RST;
      st_r.div_rl <= tsos_pkg::DIV_RST;
      st_r.div <= tsos_pkg::DIV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign arready = st_r.arready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign timer_out = st_r.tout;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic halt_wr;
  assign halt_wr = st_r.aw_v && st_r.w_v && !st_r.bvalid && st_r.w_s
    && st_r.aw_a == tsos_pkg::OFS_CTRL && st_r.w_d[tsos_pkg::HALT_BIT];

  a_reset_stopped: assert property ($past(!aresetn) |-> !st_r.act)
    else $error("timer active right after reset");
  a_start_lag: assert property ($rose(st_r.act)
    |-> $past(st_r.run_s1) && $past(st_r.tick))
    else $error("active flag rose without synced run");
  a_stop_lag: assert property ($fell(st_r.act) |-> $past(halt_wr)
    || ($past(st_r.tick) && !$past(st_r.run_s1)))
    else $error("active flag fell without synced clear");
  a_force_halt: assert property (halt_wr
    |=> !st_r.act && !st_r.osa)
    else $error("force halt did not stop at once");
  a_count_step: assert property (st_r.tick && st_r.act
    && st_r.run_s1 && st_r.mode == tsos_pkg::MODE_TIMER && st_r.pre_c != 8'h00
    && !(st_r.aw_v && st_r.w_v && !st_r.bvalid)
    |=> st_r.pre_c == $past(st_r.pre_c) - 8'h01)
    else $error("prescaler did not step on tick");
  a_stop_reload: assert property ($fell(st_r.act) && st_r.mode[1]
    && !$past(halt_wr) |-> st_r.cnt == st_r.pri_rl)
    else $error("one-shot stop did not reload");
  a_oshot_lag: assert property ($rose(st_r.osa)
    && st_r.mode == tsos_pkg::MODE_ONESHOT |-> $past(st_r.tick)
    && $past(st_r.go_s))
    else $error("one-shot flag rose without synced go");
  a_oshot_gate: assert property ($rose(st_r.osa)
    && st_r.mode == tsos_pkg::MODE_ONESHOT |-> $past(st_r.act))
    else $error("one-shot started while inactive");
  a_stopped_write: assert property (!st_r.act && st_r.aw_v
    && st_r.w_v && !st_r.bvalid && st_r.w_s && st_r.aw_a == tsos_pkg::OFS_PRI
    |=> st_r.cnt == $past(st_r.w_d[7:0]))
    else $error("stopped write missed the counter");
  a_no_retrigger: assert property (st_r.osa |-> !st_r.go_p)
    else $error("trigger accepted during one-shot");

  c_start: cover property ($rose(st_r.act));
  c_oneshot: cover property ($rose(st_r.osa));
  c_halt: cover property (halt_wr ##1 !st_r.act);
  c_underflow: cover property (st_r.tick && st_r.act && st_r.cnt == 8'h00
    && st_r.pre_c == 8'h00);

endmodule

// ==== test/test_timer_start_stop_oneshot_sync.sv ====
// Purpose: self-checking bench of the start/stop/one-shot timer
// Assumes: AXI4-Lite master in this bench, divider slows the count source
// Notes: fixed waits of 24 cycles cover two ticks at divider 7
`timescale 1ns/1ps
module test_timer_start_stop_oneshot_sync;
  // ****************************************
  // signals
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, timer_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  int fails = 0;
  int n_compared = 0;
  always #5 aclk = ~aclk;

  tsos_top tsos_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timer_out(timer_out));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // pin high time in aclk cycles; both waits bounded
  task automatic pulse_len(output int n);
    int i;
    n = 0;
    i = 0;
    while (timer_out !== 1'b1 && i < 800) begin
      @(posedge aclk);
      i++;
    end
    while (timer_out === 1'b1 && n < 800) begin
      @(posedge aclk);
      n++;
    end
    if (i >= 800 || n >= 800) begin
      fails++;
      end_of_test();
    end
  endtask
  // bready held high throughout, so no double drive between writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = tsos_pkg::RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check("bresp", bresp, er);
        return;
      end
    end
    fails++;
    end_of_test();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = tsos_pkg::RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        check("rresp", rresp, er);
        return;
      end
    end
    fails++;
    end_of_test();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(tsos_pkg::OFS_CTRL, v);
    check("ctrl", v, 32'h0000_0000);
    rd(tsos_pkg::OFS_PRE, v);
    check("pre", v, tsos_pkg::PRE_RST);
    rd(tsos_pkg::OFS_PRI, v);
    check("pri", v, tsos_pkg::CNT_RST);
    rd(tsos_pkg::OFS_DIV, v);
    check("div", v, tsos_pkg::DIV_RST);
    check("pin", timer_out, 1'b0);
    rd(8'h40, v, tsos_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, tsos_pkg::RESP_SLVERR);
  endtask
  task automatic t_start();
    wr(tsos_pkg::OFS_DIV, 32'h0000_0007); // divider source
    wr(tsos_pkg::OFS_PRE, 32'h0000_0000); // while stopped
    wr(tsos_pkg::OFS_PRI, 32'h0000_0010);
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0001);
    rd(tsos_pkg::OFS_CTRL, v);
    check("act early", v[tsos_pkg::ACT_BIT], 1'b0);
    idle(24); // no register access in the window; the flag is read after it
    rd(tsos_pkg::OFS_CTRL, v);
    check("act late", v[tsos_pkg::ACT_BIT], 1'b1);
    rd(tsos_pkg::OFS_PRI, v);
    check("counting", v[7:0] < 8'h10, 1'b1);
    wr(tsos_pkg::OFS_PRI, 32'h0000_0080); // single running write
    rd(tsos_pkg::OFS_PRI, v);
    check("reload only", v[7:0] < 8'h10, 1'b1);
  endtask
  task automatic t_stop();
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0000);
    rd(tsos_pkg::OFS_CTRL, v);
    check("act held", v[tsos_pkg::ACT_BIT], 1'b1);
    idle(24);
    rd(tsos_pkg::OFS_CTRL, v);
    check("act fell", v[tsos_pkg::ACT_BIT], 1'b0);
    wr(tsos_pkg::OFS_PRI, 32'h0000_0055);
    idle(20);
    rd(tsos_pkg::OFS_PRI, v);
    check("stopped load", v, 32'h0000_0055);
  endtask
  task automatic t_force();
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0001);
    idle(24);
    // run and halt together: halt must win without any tick delay
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0005);
    rd(tsos_pkg::OFS_CTRL, v);
    check("halted", v[2:0], 3'h0);
  endtask
  task automatic t_oneshot();
    wr(tsos_pkg::OFS_MODE, 32'h0000_0002);
    wr(tsos_pkg::OFS_PRI, 32'h0000_0030);
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0001);
    idle(24);
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0001);
    rd(tsos_pkg::OFS_OSHOT, v);
    check("osa early", v[tsos_pkg::OSACT_BIT], 1'b0);
    idle(24);
    rd(tsos_pkg::OFS_OSHOT, v);
    check("osa set", v[tsos_pkg::OSACT_BIT], 1'b1);
    check("pin high", timer_out, 1'b1);
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0001);
    idle(40);
    rd(tsos_pkg::OFS_PRI, v);
    check("no retrigger", v[7:0] < 8'h2C, 1'b1);
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0002);
    idle(24);
    rd(tsos_pkg::OFS_OSHOT, v);
    check("osa clear", v[tsos_pkg::OSACT_BIT], 1'b0);
    rd(tsos_pkg::OFS_PRI, v);
    check("halt reload", v, 32'h0000_0030);
    check("pin low", timer_out, 1'b0);
  endtask
  task automatic t_osclear();
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0001);
    idle(60);
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0000);
    idle(24);
    rd(tsos_pkg::OFS_PRI, v);
    check("run clear reload", v, 32'h0000_0030);
    // trigger while count inactive must be dropped
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0001);
    idle(24);
    rd(tsos_pkg::OFS_OSHOT, v);
    check("go dropped", v[tsos_pkg::OSACT_BIT], 1'b0);
  endtask
  task automatic t_timer_mode_go();
    wr(tsos_pkg::OFS_MODE, 32'h0000_0000);
    // stopped, so the prescaler count loads too; makes it step visibly
    wr(tsos_pkg::OFS_PRE, 32'h0000_0002);
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0001);
    idle(24);
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0001);
    idle(24);
    rd(tsos_pkg::OFS_OSHOT, v);
    check("go in timer", v[tsos_pkg::OSACT_BIT], 1'b0);
  endtask
  task automatic t_waitshot();
    int n;
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0004);
    wr(tsos_pkg::OFS_MODE, 32'h0000_0003);
    wr(tsos_pkg::OFS_PRE, 32'h0000_0001);
    wr(tsos_pkg::OFS_PRI, 32'h0000_0002);
    wr(tsos_pkg::OFS_SEC, 32'h0000_0003);
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0001);
    idle(24);
    wr(tsos_pkg::OFS_OSHOT, 32'h0000_0001);
    pulse_len(n);
    // (1+1)*(3+1) ticks of 8 aclk each
    check("wait pulse", n, 32'h0000_0040);
    rd(tsos_pkg::OFS_OSHOT, v);
    check("wait done", v[tsos_pkg::OSACT_BIT], 1'b0);
    rd(tsos_pkg::OFS_PRI, v);
    check("wait reload", v, 32'h0000_0002);
  endtask
  task automatic t_wave();
    int n;
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0004);
    wr(tsos_pkg::OFS_MODE, 32'h0000_0001);
    wr(tsos_pkg::OFS_SEC, 32'h0000_0002);
    wr(tsos_pkg::OFS_CTRL, 32'h0000_0001);
    // no register access in the window, only the pin is watched
    pulse_len(n);
    // (1+1)*(2+1) ticks of 8 aclk each
    check("wave high", n, 32'h0000_0030);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    idle(6);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_start();
    t_stop();
    t_force();
    t_oneshot();
    t_osclear();
    t_timer_mode_go();
    t_waitshot();
    t_wave();
    end_of_test();
  end
endmodule
